// ==== tib_defines.vh ====
// Functional notes
// [RULE1] Byte extract: word address is EA plus index J; byte goes to A low.
// [RULE2] Extract select J[23:22]: 01 high, 10 middle, 11 or 00 low byte.
// [RULE3] Only index bits 0-15 join the address sum, selector bits do not.
// [RULE4] Indexed final extract address: named index ORed with J before add.
// [RULE5] Byte replace: EA plus I addresses word; A low replaces selected byte.
// [RULE6] Replace select I[23:22]: 01 high, 10 middle, 11 low, 00 nothing.
// [RULE7] Indexed final replace address: named index ORed with I before add.
// [RULE8] Opcode 66 with field 1,2,3 swaps memory word with I, J or K.
// [RULE9] Memory-index swaps refuse an indexed immediate memory reference.
// [RULE10] Opcode 67 swaps memory with E, 70 with A; both set condition.
// [RULE11] Opcode 0035 swaps two registers chosen by codes 01..40.
// [RULE12] Low byte load copies memory bits 0-7 into A, keeps A 8-23.
// [RULE13] Pair load: EA word into E, following word into A.
// [RULE14] Query load maps memory bits 0-17,21,22,23 to query 0-17,18,19,20.
// [RULE15] Query load: memory bit 23 set disables trap, clear enables it.
// [RULE16] Bit 22 set traps on writes only, clear traps on any reference.
// [RULE17] Bit 21 set limits trap or halt to user mode, clear to monitor.
// [RULE18] Condition shows positive, negative or zero of the destination.
// [RULE19] Each swap completes both locations before the next instruction.
`ifndef TIB_DEFINES_VH
`define TIB_DEFINES_VH
`define TIB_WORD_W      24
`define TIB_ADDR_W      18
`define TIB_OPC_BYTE_EXTRACT   6'o31
`define TIB_OPC_BYTE_REPLACE   6'o27
`define TIB_OPC_SWAP_MEM_INDEX 6'o66
`define TIB_OPC_SWAP_MEM_EXT   6'o67
`define TIB_OPC_SWAP_MEM_ACC   6'o70
`define TIB_OPC_LOW_BYTE_LOAD  6'o07
`define TIB_OPC_PAIR_LOAD      6'o06
`define TIB_OPC_QUERY_LOAD     6'o51
`define TIB_OPC_AUGMENTED      6'o00
`define TIB_AUG_REG_SWAP       6'o35
`define TIB_SEL_HIGH    2'b01
`define TIB_SEL_MID     2'b10
`define TIB_SEL_LOW     2'b11
`define TIB_SEL_NONE    2'b00
`define TIB_SEL_MSB     23
`define TIB_SEL_LSB     22
`define TIB_IDX_MSB     15
`define TIB_Q_TRAP_OFF  20
`define TIB_Q_WR_ONLY   19
`define TIB_Q_USER      18
`define TIB_Q_W         21
`define TIB_GPR_I       3'd0
`define TIB_GPR_J       3'd1
`define TIB_GPR_K       3'd2
`define TIB_GPR_E       3'd3
`define TIB_GPR_A       3'd4
`define TIB_GPR_T       3'd5
`define TIB_GPR_NUM     6
`define TIB_COND_POS    3
`define TIB_COND_ZERO   2
`define TIB_COND_NEG    1
`define TIB_COND_OVF    0
`define TIB_COND_RST    4'h4
`define TIB_OFS_GPR_I   6'h00
`define TIB_OFS_GPR_T   6'h14
`define TIB_OFS_COND    6'h18
`define TIB_OFS_QUERY   6'h1C
`define TIB_OFS_TRAP    6'h20
`define TIB_OFS_STATUS  6'h24
`define TIB_ST_BUSY     0
`define TIB_ST_REJECT   1
`endif

// ==== tib_byte_lane.v ====
`timescale 1ns/1ns
`include "tib_defines.vh"
module tib_byte_lane (
   input  wire [23:0] word_in,
   input  wire [1:0]  sel,
   input  wire [7:0]  byte_in,
   output reg  [7:0]  byte_out,
   output reg  [23:0] word_out
);
   always @* begin
      word_out = word_in;
      case (sel)
         `TIB_SEL_HIGH: begin
            byte_out        = word_in[23:16];
            word_out[23:16] = byte_in;
         end
         `TIB_SEL_MID: begin
            byte_out       = word_in[15:8];
            word_out[15:8] = byte_in;
         end
         `TIB_SEL_LOW: begin
            byte_out      = word_in[7:0];
            word_out[7:0] = byte_in;
         end
         default: begin
            // Extract reads low byte here; replace skips memory entirely
            byte_out = word_in[7:0]; // [RULE2]
         end
      endcase
   end
endmodule // tib_byte_lane

// ==== tib_unit.v ====
// Added by the designer: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ns
`include "tib_defines.vh"
module tib_unit (
   input  wire        clk,
   input  wire        srst,
   input  wire [5:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest,
   input  wire        cmd_valid,
   output reg         cmd_ready,
   input  wire [5:0]  cmd_opc,
   input  wire [5:0]  cmd_aug,
   input  wire [1:0]  cmd_rfield,
   input  wire [5:0]  cmd_rsel1,
   input  wire [5:0]  cmd_rsel2,
   input  wire [1:0]  cmd_final_index,
   input  wire        cmd_imm_indexed,
   input  wire [17:0] cmd_ea,
   output reg         done,
   output reg         reject,
   output reg         mem_req,
   output reg         mem_we,
   output reg  [17:0] mem_addr,
   output reg  [23:0] mem_wdata,
   input  wire [23:0] mem_rdata,
   input  wire        mem_ack,
   output reg  [3:0]  cond,
   output reg  [20:0] query,
   output reg         trap_enable,
   output reg         trap_write_only,
   output reg         trap_user_mode
);
   localparam S_IDLE = 2'd0;
   localparam S_RD   = 2'd1;
   localparam S_RD2  = 2'd2;
   localparam S_WR   = 2'd3;

   reg  [23:0] gpr_reg [0:5];
   reg  [1:0]  state_reg;
   reg  [5:0]  op_reg;
   reg  [2:0]  tgt_reg;
   reg  [1:0]  sel_reg;
   reg  [23:0] hold_reg;
   reg         reject_sticky_reg;
   reg  [2:0]  r1_idx;
   reg  [2:0]  r2_idx;
   reg         r1_ok;
   reg         r2_ok;
   reg  [23:0] extract_idx;
   reg  [23:0] replace_idx;
   reg  [23:0] named_idx;
   reg  [31:0] rd_mux;
   reg  [2:0]  swap_tgt;
   wire [7:0]  lane_byte;
   wire [23:0] lane_word;
   wire [3:0]  bus_word;

   assign bus_word = avs_address[5:2];

   // Maps a one-hot register select code to a file index
   function [3:0] sel_decode;
      input [5:0] code;
      begin
         case (code)
            6'h01:   sel_decode = {1'b1, `TIB_GPR_I};
            6'h02:   sel_decode = {1'b1, `TIB_GPR_J};
            6'h04:   sel_decode = {1'b1, `TIB_GPR_K};
            6'h08:   sel_decode = {1'b1, `TIB_GPR_E};
            6'h10:   sel_decode = {1'b1, `TIB_GPR_A};
            6'h20:   sel_decode = {1'b1, `TIB_GPR_T};
            default: sel_decode = {1'b0, 3'd0};
         endcase
      end
   endfunction

   // Positive / zero / negative of a result, overflow kept
   function [3:0] cond_of;
      input [23:0] v;
      input        ovf;
      begin
         cond_of[`TIB_COND_POS]  = ~v[23] & (|v);
         cond_of[`TIB_COND_ZERO] = ~(|v);
         cond_of[`TIB_COND_NEG]  = v[23];
         cond_of[`TIB_COND_OVF]  = ovf;
      end
   endfunction

   // Extract and replace share one lane unit; op decides which side
   tib_byte_lane u_lane (
      .word_in  (mem_rdata),
      .sel      (sel_reg),
      .byte_in  (gpr_reg[`TIB_GPR_A][7:0]),
      .byte_out (lane_byte),
      .word_out (lane_word)
   );

   always @* begin
      {r1_ok, r1_idx} = sel_decode(cmd_rsel1);
      {r2_ok, r2_idx} = sel_decode(cmd_rsel2);
      case (cmd_final_index)
         2'd1:    named_idx = gpr_reg[`TIB_GPR_I];
         2'd2:    named_idx = gpr_reg[`TIB_GPR_J];
         2'd3:    named_idx = gpr_reg[`TIB_GPR_K];
         default: named_idx = 24'h000000;
      endcase
      extract_idx = gpr_reg[`TIB_GPR_J] | named_idx; // [RULE4]
      replace_idx = gpr_reg[`TIB_GPR_I] | named_idx; // [RULE7]
      case (cmd_rfield)
         2'd1:    swap_tgt = `TIB_GPR_I; // [RULE8]
         2'd2:    swap_tgt = `TIB_GPR_J;
         default: swap_tgt = `TIB_GPR_K;
      endcase
      rd_mux = 32'h00000000;
      if (avs_address <= `TIB_OFS_GPR_T) begin
         rd_mux[23:0] = gpr_reg[bus_word[2:0]];
      end else begin
         case (avs_address)
            `TIB_OFS_COND:   rd_mux[3:0] = cond;
            `TIB_OFS_QUERY:  rd_mux[20:0] = query;
            `TIB_OFS_TRAP:   rd_mux[2:0] =
               {trap_user_mode, trap_write_only, trap_enable};
            `TIB_OFS_STATUS: rd_mux[1:0] =
               {reject_sticky_reg, state_reg != S_IDLE};
            default:         rd_mux = 32'h00000000;
         endcase
      end
   end

   always @(posedge clk) begin
      if (srst) begin
         gpr_reg[0]        <= 24'h000000;
         gpr_reg[1]        <= 24'h000000;
         gpr_reg[2]        <= 24'h000000;
         gpr_reg[3]        <= 24'h000000;
         gpr_reg[4]        <= 24'h000000;
         gpr_reg[5]        <= 24'h000000;
         state_reg         <= S_IDLE;
         op_reg            <= 6'h00;
         tgt_reg           <= 3'd0;
         sel_reg           <= 2'b00;
         hold_reg          <= 24'h000000;
         reject_sticky_reg <= 1'b0;
         avs_readdata      <= 32'h00000000;
         avs_waitrequest   <= 1'b1;
         cmd_ready         <= 1'b1;
         done              <= 1'b0;
         reject            <= 1'b0;
         mem_req           <= 1'b0;
         mem_we            <= 1'b0;
         mem_addr          <= 18'h00000;
         mem_wdata         <= 24'h000000;
         cond              <= `TIB_COND_RST;
         query             <= 21'h000000;
         trap_enable       <= 1'b0;
         trap_write_only   <= 1'b0;
         trap_user_mode    <= 1'b0;
      end else begin
         done            <= 1'b0;
         reject          <= 1'b0;
         avs_waitrequest <= 1'b1;
         case (state_reg)
            S_IDLE: begin
               if (cmd_ready && cmd_valid) begin
                  cmd_ready <= 1'b0;
                  op_reg    <= cmd_opc;
                  mem_addr  <= cmd_ea;
                  mem_we    <= 1'b0;
                  case (cmd_opc)
                     `TIB_OPC_BYTE_EXTRACT: begin
                        mem_addr  <= cmd_ea +
                           {2'b00, extract_idx[`TIB_IDX_MSB:0]}; // [RULE1] [RULE3]
                        sel_reg   <= extract_idx[23:22]; // [RULE2]
                        mem_req   <= 1'b1;
                        state_reg <= S_RD;
                     end
                     `TIB_OPC_BYTE_REPLACE: begin
                        mem_addr <= cmd_ea +
                           {2'b00, replace_idx[`TIB_IDX_MSB:0]}; // [RULE5] [RULE3]
                        sel_reg  <= replace_idx[23:22];
                        if (replace_idx[23:22] == `TIB_SEL_NONE) begin
                           done      <= 1'b1; // [RULE6]
                           cmd_ready <= 1'b1;
                        end else begin
                           mem_req   <= 1'b1;
                           state_reg <= S_RD;
                        end
                     end
                     `TIB_OPC_SWAP_MEM_INDEX: begin
                        if (cmd_imm_indexed || cmd_rfield == 2'd0) begin
                           reject            <= 1'b1; // [RULE9]
                           reject_sticky_reg <= 1'b1;
                           cmd_ready         <= 1'b1;
                        end else begin
                           tgt_reg   <= swap_tgt; // [RULE8]
                           mem_req   <= 1'b1;
                           state_reg <= S_RD;
                        end
                     end
                     `TIB_OPC_SWAP_MEM_EXT, `TIB_OPC_SWAP_MEM_ACC: begin
                        tgt_reg   <= (cmd_opc == `TIB_OPC_SWAP_MEM_EXT) ?
                                     `TIB_GPR_E : `TIB_GPR_A; // [RULE10]
                        mem_req   <= 1'b1;
                        state_reg <= S_RD;
                     end
                     `TIB_OPC_LOW_BYTE_LOAD, `TIB_OPC_PAIR_LOAD,
                     `TIB_OPC_QUERY_LOAD: begin
                        mem_req   <= 1'b1;
                        state_reg <= S_RD;
                     end
                     `TIB_OPC_AUGMENTED: begin
                        cmd_ready <= 1'b1;
                        if (cmd_aug == `TIB_AUG_REG_SWAP && r1_ok && r2_ok &&
                            r1_idx != r2_idx) begin
                           gpr_reg[r1_idx] <= gpr_reg[r2_idx]; // [RULE11]
                           gpr_reg[r2_idx] <= gpr_reg[r1_idx]; // [RULE19]
                           cond <= cond_of(gpr_reg[r1_idx],
                                           cond[`TIB_COND_OVF]); // [RULE18]
                           done <= 1'b1;
                        end else begin
                           reject            <= 1'b1;
                           reject_sticky_reg <= 1'b1;
                        end
                     end
                     default: begin
                        reject            <= 1'b1;
                        reject_sticky_reg <= 1'b1;
                        cmd_ready         <= 1'b1;
                     end
                  endcase
               end else if ((avs_read || avs_write) && avs_waitrequest &&
                            !cmd_valid) begin
                  // Bus waits while an instruction runs, so swaps stay whole
                  avs_waitrequest <= 1'b0; // [RULE19]
                  avs_readdata    <= rd_mux;
                  if (avs_write) begin
                     if (avs_address <= `TIB_OFS_GPR_T) begin
                        gpr_reg[bus_word[2:0]] <= avs_writedata[23:0];
                     end else if (avs_address == `TIB_OFS_COND) begin
                        cond <= avs_writedata[3:0];
                     end else if (avs_address == `TIB_OFS_STATUS &&
                                  avs_writedata[`TIB_ST_REJECT]) begin
                        reject_sticky_reg <= 1'b0;
                     end
                  end
               end
            end
            S_RD: begin
               if (mem_ack) begin
                  hold_reg <= mem_rdata;
                  case (op_reg)
                     `TIB_OPC_BYTE_EXTRACT: begin
                        gpr_reg[`TIB_GPR_A][7:0] <= lane_byte; // [RULE1]
                        cond <= cond_of({gpr_reg[`TIB_GPR_A][23:8],
                                        lane_byte}, cond[0]); // [RULE18]
                        mem_req   <= 1'b0;
                        done      <= 1'b1;
                        cmd_ready <= 1'b1;
                        state_reg <= S_IDLE;
                     end
                     `TIB_OPC_BYTE_REPLACE: begin
                        mem_wdata <= lane_word; // [RULE5] [RULE6]
                        mem_we    <= 1'b1;
                        state_reg <= S_WR;
                     end
                     `TIB_OPC_LOW_BYTE_LOAD: begin
                        gpr_reg[`TIB_GPR_A][7:0] <= mem_rdata[7:0]; // [RULE12]
                        cond <= cond_of({gpr_reg[`TIB_GPR_A][23:8],
                                        mem_rdata[7:0]}, cond[0]); // [RULE18]
                        mem_req   <= 1'b0;
                        done      <= 1'b1;
                        cmd_ready <= 1'b1;
                        state_reg <= S_IDLE;
                     end
                     `TIB_OPC_PAIR_LOAD: begin
                        gpr_reg[`TIB_GPR_E] <= mem_rdata; // [RULE13]
                        mem_addr  <= mem_addr + 18'h00001;
                        state_reg <= S_RD2;
                     end
                     `TIB_OPC_QUERY_LOAD: begin
                        query <= {mem_rdata[23:21],
                                  mem_rdata[17:0]}; // [RULE14]
                        trap_enable     <= ~mem_rdata[23]; // [RULE15]
                        trap_write_only <= mem_rdata[22]; // [RULE16]
                        trap_user_mode  <= mem_rdata[21]; // [RULE17]
                        mem_req   <= 1'b0;
                        done      <= 1'b1;
                        cmd_ready <= 1'b1;
                        state_reg <= S_IDLE;
                     end
                     default: begin
                        // All memory swaps: old register goes out first
                        mem_wdata <= gpr_reg[tgt_reg]; // [RULE8] [RULE10]
                        mem_we    <= 1'b1;
                        state_reg <= S_WR;
                     end
                  endcase
               end
            end
            S_RD2: begin
               if (mem_ack) begin
                  gpr_reg[`TIB_GPR_A] <= mem_rdata; // [RULE13]
                  cond[`TIB_COND_NEG]  <= gpr_reg[`TIB_GPR_E][23]; // [RULE18]
                  cond[`TIB_COND_ZERO] <=
                     ~(|{gpr_reg[`TIB_GPR_E], mem_rdata});
                  cond[`TIB_COND_POS]  <= ~gpr_reg[`TIB_GPR_E][23] &
                     (|{gpr_reg[`TIB_GPR_E], mem_rdata});
                  mem_req   <= 1'b0;
                  done      <= 1'b1;
                  cmd_ready <= 1'b1;
                  state_reg <= S_IDLE;
               end
            end
            S_WR: begin
               if (mem_ack) begin
                  mem_req <= 1'b0;
                  mem_we  <= 1'b0;
                  if (op_reg != `TIB_OPC_BYTE_REPLACE) begin
                     // Register changes only once memory holds its old value
                     gpr_reg[tgt_reg] <= hold_reg; // [RULE19]
                     cond <= cond_of(hold_reg, cond[0]); // [RULE10] [RULE18]
                  end
                  done      <= 1'b1;
                  cmd_ready <= 1'b1;
                  state_reg <= S_IDLE;
               end
            end
            default: begin
               state_reg <= S_IDLE;
               cmd_ready <= 1'b1;
            end
         endcase
      end
   end
endmodule // tib_unit

// ==== tib_mem_model.sv ====
`timescale 1ns/1ns
module tib_mem_model (
   input  wire        clk,
   input  wire        mem_req,
   input  wire        mem_we,
   input  wire [17:0] mem_addr,
   input  wire [23:0] mem_wdata,
   input  wire [1:0]  lag,
   output reg  [23:0] mem_rdata = 24'h000000,
   output reg         mem_ack = 1'b0
);
   reg [23:0] mem [0:63];
   reg [1:0]  cnt_reg = 2'h0;

   // Toggling data exposes stale samples
   always @(posedge clk) begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
         if (cnt_reg == lag) begin
            cnt_reg <= 2'h0;
            mem_ack <= 1'b1;
            if (mem_we)
               mem[mem_addr[5:0]] <= mem_wdata;
            else
               mem_rdata <= mem[mem_addr[5:0]];
         end else
            cnt_reg <= cnt_reg + 2'h1;
      end
   end
endmodule // tib_mem_model

// ==== tib_unit_sva.sv ====
`timescale 1ns/1ns
module tib_unit_sva (
   input wire        clk,
   input wire        srst,
   input wire        avs_waitrequest,
   input wire        cmd_valid,
   input wire        cmd_ready,
   input wire [5:0]  cmd_opc,
   input wire        cmd_imm_indexed,
   input wire        done,
   input wire        reject,
   input wire        mem_req,
   input wire        mem_we,
   input wire [17:0] mem_addr,
   input wire        mem_ack,
   input wire [3:0]  cond,
   input wire [20:0] query,
   input wire        trap_enable,
   input wire        trap_write_only,
   input wire        trap_user_mode
);
   wire take = cmd_valid && cmd_ready;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);

   take_busy_a: assert property (take
      |=> cmd_ready == (done || reject))
      else $error("ready wrong after a take");
   ready_back_a: assert property ($rose(cmd_ready) |-> done || reject)
      else $error("ready back without pulse");
   imm_refuse_a: assert property (take && cmd_opc == 6'h36 &&
      cmd_imm_indexed |=> reject && !mem_req)
      else $error("indexed swap not refused");
   reg_swap_a: assert property (take && cmd_opc == 6'h00
      |=> (done || reject) && !mem_req)
      else $error("register swap slow");
   write_order_a: assert property ($rose(mem_we)
      |-> $past(mem_ack) && mem_req && $stable(mem_addr))
      else $error("write not after read");
   req_hold_a: assert property (mem_req && !mem_ack
      |=> mem_req && $stable(mem_addr) && $stable(mem_we))
      else $error("request moved early");
   trap_map_a: assert property (
      $changed(query) |-> done && trap_enable == !query[20]
      && trap_write_only == query[19] && trap_user_mode == query[18])
      else $error("trap bits disagree");
   cond_cause_a: assert property (
      $changed(cond) |-> done || !avs_waitrequest)
      else $error("cond changed uncaused");
   cond_status_a: assert property (
      done && $changed(cond[3:1]) |-> $onehot(cond[3:1]))
      else $error("cond not one-hot");
   ovf_keep_a: assert property (done |-> cond[0] == $past(cond[0]))
      else $error("overflow altered");
endmodule // tib_unit_sva

bind tib_unit tib_unit_sva u_sva (
   .clk(clk), .srst(srst), .avs_waitrequest(avs_waitrequest),
   .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_opc(cmd_opc),
   .cmd_imm_indexed(cmd_imm_indexed), .done(done), .reject(reject),
   .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
   .mem_ack(mem_ack), .cond(cond), .query(query),
   .trap_enable(trap_enable), .trap_write_only(trap_write_only),
   .trap_user_mode(trap_user_mode)
);

// ==== transfer_interchange_byte_unit_tb.sv ====
`timescale 1ns/1ns
module transfer_interchange_byte_unit_tb;
   reg         clk, srst, avs_read, avs_write, cmd_valid, cmd_imm_indexed;
   reg  [5:0]  avs_address, cmd_opc, cmd_aug, cmd_rsel1, cmd_rsel2, a;
   reg  [31:0] avs_writedata, rv, rj;
   reg  [1:0]  cmd_rfield, cmd_final_index, lag;
   reg  [17:0] cmd_ea;
   reg  [23:0] v;
   wire [31:0] avs_readdata;
   wire        avs_waitrequest, cmd_ready, done, reject, mem_req, mem_we;
   wire        mem_ack, trap_enable, trap_write_only, trap_user_mode;
   wire [17:0] mem_addr;
   wire [23:0] mem_wdata, mem_rdata;
   wire [3:0]  cond;
   wire [20:0] query;
   integer     fail_count, total_checks, i, k;

   tib_unit u_dut (
      .clk(clk), .srst(srst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_opc(cmd_opc), .cmd_aug(cmd_aug),
      .cmd_rfield(cmd_rfield), .cmd_rsel1(cmd_rsel1),
      .cmd_rsel2(cmd_rsel2), .cmd_final_index(cmd_final_index),
      .cmd_imm_indexed(cmd_imm_indexed), .cmd_ea(cmd_ea), .done(done),
      .reject(reject), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
      .mem_ack(mem_ack), .cond(cond), .query(query),
      .trap_enable(trap_enable), .trap_write_only(trap_write_only),
      .trap_user_mode(trap_user_mode)
   );
   tib_mem_model u_mem (
      .clk(clk), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .lag(lag), .mem_rdata(mem_rdata),
      .mem_ack(mem_ack)
   );

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task chk(input string nm, input [31:0] e, input [31:0] g);
      total_checks = total_checks + 1;
      if (g !== e) begin
         fail_count = fail_count + 1;
         $display("[ERR] %0s expected %h seen %h", nm, e, g);
      end
   endtask

   // Idle edge so no strobe is set twice per step
   task bus(input w, input [5:0] ad, input [31:0] d);
      avs_write <= w;
      avs_read <= !w;
      avs_address <= ad;
      avs_writedata <= d;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      rv = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask

   task rd(input [5:0] ad, input [31:0] e, input string nm);
      bus(1'b0, ad, 32'h0);
      chk(nm, e, rv);
   endtask

   task exec(input [5:0] o, input [5:0] g, input [1:0] rf, input [5:0] s1,
      input [5:0] s2, input [1:0] fx, input im, input [17:0] ea);
      cmd_opc <= o;
      cmd_aug <= g;
      cmd_rfield <= rf;
      cmd_rsel1 <= s1;
      cmd_rsel2 <= s2;
      cmd_final_index <= fx;
      cmd_imm_indexed <= im;
      cmd_ea <= ea;
      cmd_valid <= 1'b1;
      @(posedge clk);
      cmd_valid <= 1'b0;
      while (done !== 1'b1 && reject !== 1'b1) @(posedge clk);
      rj = {31'h0, reject};
   endtask

   task mop(input [5:0] o, input [1:0] rf, input [1:0] fx, input [17:0] ea);
      exec(o, 6'h00, rf, 6'h00, 6'h00, fx, 1'b0, ea);
   endtask

   task tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      fail_count = fail_count + 1;
      tally_and_finish;
   end

   initial begin
      fail_count = 0;
      total_checks = 0;
      srst = 1'b1;
      {avs_read, avs_write, avs_address, avs_writedata} = 40'h0;
      {cmd_valid, cmd_imm_indexed, cmd_opc, cmd_aug} = 14'h0;
      {cmd_rsel1, cmd_rsel2, cmd_rfield, cmd_final_index} = 16'h0;
      cmd_ea = 18'h0;
      lag = 2'h0;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      for (a = 6'h00; a < 6'h28; a = a + 6'h04)
         rd(a, (a == 6'h18) ? 32'h4 : 32'h0, "reset value");
      bus(1'b1, 6'h3C, 32'hFFFFFFFF);
      rd(6'h3C, 32'h0, "unmapped");
      bus(1'b1, 6'h14, 32'hFF123456);
      rd(6'h14, 32'h00123456, "upper bits");
      u_mem.mem[6'h30] = 24'hABCDEF;
      u_mem.mem[6'h34] = 24'h13579B;
      bus(1'b1, 6'h08, 32'h4);
      for (i = 0; i < 4; i = i + 1) begin
         bus(1'b1, 6'h10, 32'h123400);
         bus(1'b1, 6'h04, {8'h00, i[1:0], 6'h2A, 16'h0010});
         mop(6'h19, 2'h0, 2'h0, 18'h00020);
         v = (i == 1) ? 24'h1234AB : (i == 2) ? 24'h1234CD : 24'h1234EF;
         rd(6'h10, {8'h00, v}, "extract");
         chk("extract cond", 32'h8, {28'h0, cond});
      end
      mop(6'h19, 2'h0, 2'h3, 18'h00020);
      rd(6'h10, 32'h12349B, "indexed extract");
      bus(1'b1, 6'h10, 32'h5C);
      bus(1'b1, 6'h04, 32'h1);
      for (i = 0; i < 4; i = i + 1) begin
         u_mem.mem[6'h20] = 24'h112233;
         bus(1'b1, 6'h00, {8'h00, i[1:0], 6'h15, 16'h0008});
         mop(6'h17, 2'h0, 2'h0, 18'h00018);
         v = (i == 1) ? 24'h5C2233 : (i == 2) ? 24'h115C33 : 24'h112233;
         v = (i == 3) ? 24'h11225C : v;
         chk("replace", {8'h00, v}, {8'h00, u_mem.mem[6'h20]});
      end
      u_mem.mem[6'h21] = 24'h112233;
      mop(6'h17, 2'h0, 2'h2, 18'h00018);
      chk("indexed replace", 32'h11225C, {8'h00, u_mem.mem[6'h21]});
      // Memory lag rises from 0 to 3 over the first four swaps, no lag on the fifth
      for (i = 0; i < 5; i = i + 1) begin
         lag <= i[1:0];
         v = (i == 0) ? 24'h000000 : (i == 1) ? 24'h900001 : 24'h000107;
         u_mem.mem[6'h38] = v;
         bus(1'b1, {i[3:0], 2'h0}, 32'hA00000 + i);
         k = (i < 3) ? 6'h36 : (i == 3) ? 6'h37 : 6'h38;
         mop(k[5:0], i[1:0] + 2'h1, 2'h0, 18'h00038);
         rd({i[3:0], 2'h0}, {8'h00, v}, "swap register");
         chk("swap memory", 32'hA00000 + i,
            {8'h00, u_mem.mem[6'h38]});
         chk("swap cond", (i == 0) ? 32'h4 : (i == 1) ? 32'h2 : 32'h8,
            {28'h0, cond});
      end
      lag <= 2'h0;
      exec(6'h36, 6'h00, 2'h1, 6'h00, 6'h00, 2'h0, 1'b1, 18'h00038);
      chk("refuse imm", 32'h1, rj);
      chk("mem kept", 32'hA00004, {8'h00, u_mem.mem[6'h38]});
      mop(6'h36, 2'h0, 2'h0, 18'h00038);
      chk("refuse field", 32'h1, rj);
      exec(6'h00, 6'h1E, 2'h0, 6'h01, 6'h02, 2'h0, 1'b0, 18'h0);
      chk("refuse aug", 32'h1, rj);
      exec(6'h00, 6'h1D, 2'h0, 6'h04, 6'h04, 2'h0, 1'b0, 18'h0);
      chk("refuse same", 32'h1, rj);
      mop(6'h3F, 2'h0, 2'h0, 18'h0);
      chk("refuse opcode", 32'h1, rj);
      rd(6'h24, 32'h2, "sticky reject");
      bus(1'b1, 6'h24, 32'h2);
      rd(6'h24, 32'h0, "reject cleared");
      for (i = 0; i < 6; i = i + 1) begin
         k = (i + 1) % 6;
         bus(1'b1, {i[3:0], 2'h0}, 32'h5A5A0 + i);
         bus(1'b1, {k[3:0], 2'h0}, 32'hF0F0 + k);
         exec(6'h00, 6'h1D, 2'h0, 6'h01 << i, 6'h01 << k, 2'h0, 1'b0, 18'h0);
         rd({i[3:0], 2'h0}, 32'hF0F0 + k, "swap first");
         rd({k[3:0], 2'h0}, 32'h5A5A0 + i, "swap second");
         chk("pair swap cond", 32'h8, {28'h0, cond});
      end
      bus(1'b1, 6'h10, 32'h876543);
      u_mem.mem[6'h3A] = 24'h5555F1;
      mop(6'h07, 2'h0, 2'h0, 18'h0003A);
      rd(6'h10, 32'h8765F1, "low byte load");
      chk("low byte cond", 32'h2, {28'h0, cond});
      bus(1'b1, 6'h18, 32'h9);
      u_mem.mem[6'h2E] = 24'h7FFFFF;
      u_mem.mem[6'h2F] = 24'h000001;
      mop(6'h06, 2'h0, 2'h0, 18'h0002E);
      rd(6'h0C, 32'h7FFFFF, "pair first");
      rd(6'h10, 32'h000001, "pair second");
      chk("pair cond", 32'h9, {28'h0, cond});
      for (i = 0; i < 3; i = i + 1) begin
         v = (i == 0) ? 24'hFFFFFF : (i == 1) ? 24'h1C5A5A : 24'hA00003;
         u_mem.mem[6'h3B] = v;
         mop(6'h29, 2'h0, 2'h0, 18'h0003B);
         chk("query", {11'h0, v[23:21], v[17:0]}, {11'h0, query});
         chk("trap", {29'h0, v[21], v[22], ~v[23]}, {29'h0, trap_user_mode,
            trap_write_only, trap_enable});
      end
      rd(6'h1C, {11'h0, v[23:21], v[17:0]}, "query reg");
      rd(6'h20, {29'h0, v[21], v[22], ~v[23]}, "trap reg");
      tally_and_finish;
   end
endmodule // transfer_interchange_byte_unit_tb
